// ---- flash_led_pkg.sv ----
package flash_led_pkg;

  // Register byte offsets on the serial register port
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_DIMMING = 8'h01;
  localparam logic [7:0] OFS_INDICATOR = 8'h02;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h03;

  // Command register bit positions
  localparam int unsigned CMD_POWER_UP = 7;
  localparam int unsigned CMD_STROBE_EN = 6;
  localparam int unsigned CMD_TORCH_ON = 5;
  localparam int unsigned CMD_NTC_ON = 4;
  localparam int unsigned CMD_TMO_HI = 3;
  localparam int unsigned CMD_TMO_LO = 0;

  // Dimming and indicator register field positions
  localparam int unsigned DIM_TORCH_HI = 7;
  localparam int unsigned DIM_TORCH_LO = 4;
  localparam int unsigned DIM_FLASH_HI = 3;
  localparam int unsigned DIM_FLASH_LO = 0;
  localparam int unsigned IND_CUR_HI = 7;
  localparam int unsigned IND_CUR_LO = 4;
  localparam int unsigned IND_TIME_HI = 3;
  localparam int unsigned IND_TIME_LO = 0;

  // Fault status bit positions
  localparam int unsigned ST_FLASH_RUN = 6;
  localparam int unsigned ST_LED_OPEN = 5;
  localparam int unsigned ST_TEMP_WARN = 4;
  localparam int unsigned ST_TEMP_EXCESS = 3;
  localparam int unsigned ST_CHIP_OT = 2;
  localparam int unsigned ST_OUT_SHORT = 0;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Indicator on-time code that means continuous light
  localparam logic [3:0] IND_TIME_CONT = 4'hF;

  // Indicator current in 0.1 mA units is code * 40 / 3
  localparam logic [9:0] IND_CUR_NUM = 10'h028;
  localparam logic [9:0] IND_CUR_DEN = 10'h003;

  // Step offsets of the torch and flash level codes, path split step
  localparam logic [4:0] TORCH_STEP_BASE = 5'h01;
  localparam logic [4:0] FLASH_STEP_BASE = 5'h09;
  localparam logic [4:0] FLASH_PATH_STEP = 5'h0D;

  // Timing, in the units printed, and their cycle counts at 40 MHz
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned STEP_MS = 100;
  localparam int unsigned PRECHARGE_US = 360;
  localparam int unsigned POR_US = 1;
  localparam int unsigned STEP_CYC_DEF = CLK_KHZ * STEP_MS;
  localparam int unsigned PRECHARGE_CYC_DEF = CLK_KHZ * PRECHARGE_US / 1000;
  localparam int unsigned POR_CYC = CLK_KHZ * POR_US / 1000;
  localparam int unsigned CNT_W = 22;

  // Open-LED comparator must hold this many cycles to count
  localparam logic [2:0] OPEN_FILT_LEN = 3'h7;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_POR       = 3'h0,
    MODE_SHUTDOWN  = 3'h1,
    MODE_PRECHARGE = 3'h2,
    MODE_READY     = 3'h3,
    MODE_TORCH     = 3'h4,
    MODE_FLASH     = 3'h5
  } mode_t;

endpackage : flash_led_pkg

// ---- sync2.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser, one stage pair per bit
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // First stage feeds only the second stage
  logic [W-1:0] meta_r;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // Per-bit pair keeps metastability away from logic
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          meta_r[gi] <= 1'b0;
          sync_o[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_o[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule : sync2

// ---- indicator_timer.sv ----
`timescale 1ns/1ps

// Indicator on-time timer, started by a nonzero current code write
module indicator_timer
  import flash_led_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       load_i,       // Indicator register write
  input  wire logic [3:0] cur_code_i,   // Current code being written
  input  wire logic [3:0] on_time_i,    // On-time code being written
  output logic            lit_o         // Timer says source is on
);

  logic [CNT_W-1:0] sub_r;     // Cycles within one 100 ms step
  logic [3:0]       steps_r;   // Whole steps still to run
  logic             cont_r;    // Continuous light selected

  // Only a write of the current code switches the source on
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lit_o   <= 1'b0;
      cont_r  <= 1'b0;
      steps_r <= 4'h0;
      sub_r   <= '0;
    end else if (load_i) begin
      // Zero code turns off; on-time 0 has no time, so stays dark
      lit_o   <= (cur_code_i != 4'h0) && (on_time_i != 4'h0); // R3 R4
      cont_r  <= (on_time_i == IND_TIME_CONT);               // R2
      steps_r <= on_time_i;                                  // R1
      sub_r   <= '0;
    end else if (lit_o && !cont_r) begin
      if (sub_r == CNT_W'(STEP_CYCLES - 1)) begin
        sub_r   <= '0;
        steps_r <= steps_r - 4'h1;
        // Last step elapsed: programmed time is over
        if (steps_r == 4'h1) begin
          lit_o <= 1'b0;                                     // R3
        end
      end else begin
        sub_r <= sub_r + CNT_W'(1);                          // R1
      end
    end
  end

endmodule : indicator_timer

// ---- flash_led_ctrl.sv ----
`timescale 1ns/1ps

// Operation
// R1 - On-time codes 1-14 give 100 ms steps
// R2 - On-time code 15 keeps indicator lit
// R3 - Nonzero current write starts timer, expiry stops
// R4 - Only current code writes switch indicator
// R5 - Indicator current linear, 1.3 mA per code
// R6 - Torch steps 1-16, flash steps 9-24
// R7 - Flash-running bit follows live flash mode
// R8 - Open LED sets fault, returns ready
// R9 - Temperature warning sets bit, alert, no change
// R10 - Excess temperature sets bit, alert, ready
// R11 - Chip overtemperature sets bit, alert, ready
// R12 - Start-up precharge, short flag, abort on failure
// R13 - Status read clears latched fault bits
// R14 - Faults pull alert; most force ready
// R15 - Reset period ignores inputs, samples address
// R16 - Shutdown keeps serial port; power bit clear
// R17 - Ready: converter off, indicator usable only
// R18 - Ready entry from shutdown, flash, torch
// R19 - Host rearms strobe enable, loads timeout first
// R20 - Flash lasts as long as strobe pulse
// R21 - Timeout accumulates, reloads on command write
// R22 - Timeout clears enable, ready, alert
// R23 - Flash needs enable, strobe pin, power bit
// R24 - Timeout field 100 ms per count, unchanged
// R25 - Alert released when nothing is pending
module flash_led_ctrl
  import flash_led_pkg::*;
#(
  parameter int unsigned STEP_CYCLES      = STEP_CYC_DEF,
  parameter int unsigned PRECHARGE_CYCLES = PRECHARGE_CYC_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,              // Power-on reset
  // Register port from the serial slave, same clock
  input  wire logic       reg_wr_i,            // One-cycle write strobe
  input  wire logic       reg_rd_i,            // One-cycle read strobe
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,         // Valid after read
  // Pins and comparators, all asynchronous
  input  wire logic       strobe_pin_input_i,
  input  wire logic       addr_sel_pin_i,
  input  wire logic       led_open_cmp_i,
  input  wire logic       temp_warn_cmp_i,
  input  wire logic       temp_excess_cmp_i,
  input  wire logic       chip_overtemp_i,
  input  wire logic       vout_ok_cmp_i,
  // Open-drain alert pin
  output logic            alert_n_pin_o,
  output logic            alert_n_pin_oe_o,
  // Controls toward the analog side
  output logic            slave_addr_sel_o,    // Address caught at reset
  output logic            analog_en_o,
  output logic            precharge_en_o,
  output logic            converter_en_o,
  output logic            ntc_monitor_en_o,
  output logic [4:0]      led_step_o,          // 0 when LED idle
  output logic            sense_flash_only_o,
  output logic            indicator_on_o,
  output logic [7:0]      indicator_current_o, // 0.1 mA units
  output logic            flash_active_o
);

  mode_t            mode_r;          // Operating mode
  mode_t            mode_nxt;
  logic [7:0]       cmd_r;           // Command register
  logic [7:0]       dim_r;           // Dimming register
  logic [7:0]       ind_r;           // Indicator register
  logic [5:0]       por_cnt_r;       // Reset period counter
  logic [CNT_W-1:0] pre_cnt_r;       // Precharge counter
  logic [CNT_W-1:0] tmo_sub_r;       // Cycles inside one timeout step
  logic [3:0]       tmo_left_r;      // Timeout steps left
  logic             tmo_pend_r;      // Timeout alert not yet read
  logic             led_open_r;      // Latched fault flags
  logic             temp_warn_r;
  logic             temp_excess_r;
  logic             chip_ot_r;
  logic             out_short_r;
  logic [2:0]       open_filt_r;     // Open-LED hold counter
  logic             ind_lit;         // Indicator timer output
  logic [6:0]       pins_s;          // Synchronised inputs
  logic [9:0]       ind_prod;        // Indicator current product

  // Named views of the synchronised inputs
  logic strobe_s, addr_s, open_s, warn_s, excess_s, ot_s, vok_s;
  assign {strobe_s, addr_s, open_s, warn_s, excess_s, ot_s, vok_s} = pins_s;

  // Pins cross from outside the clock domain through two flops
  sync2 #(
    .W (7)
  ) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i ({strobe_pin_input_i, addr_sel_pin_i, led_open_cmp_i,
               temp_warn_cmp_i, temp_excess_cmp_i, chip_overtemp_i,
               vout_ok_cmp_i}),
    .sync_o  (pins_s)
  );

  // Register accesses are ignored until the reset period ends
  logic in_por;
  logic wr_ok;
  logic stat_rd;
  assign in_por  = (mode_r == MODE_POR);                       // R15
  assign wr_ok   = reg_wr_i && !in_por;
  assign stat_rd = reg_rd_i && !in_por &&
                   (reg_addr_i == OFS_FAULT_STATUS);

  logic cmd_wr;
  logic ind_wr;
  assign cmd_wr = wr_ok && (reg_addr_i == OFS_COMMAND);
  assign ind_wr = wr_ok && (reg_addr_i == OFS_INDICATOR);

  // Mode decodes
  logic led_on;
  logic flash_req;
  logic tmo_hit;
  logic ntc_active;
  assign led_on    = (mode_r == MODE_TORCH) || (mode_r == MODE_FLASH);
  // Strobe enable, strobe pin and power bit all meet in this AND
  assign flash_req = cmd_r[CMD_STROBE_EN] && strobe_s &&
                     cmd_r[CMD_POWER_UP];                      // R23
  assign tmo_hit   = (mode_r == MODE_FLASH) && (tmo_left_r == 4'h0);
  // Temperature comparators always watch while the LED runs
  assign ntc_active = led_on ||
                      ((mode_r == MODE_READY) && cmd_r[CMD_NTC_ON]);

  // Fault events in this cycle
  logic open_evt;
  logic warn_evt;
  logic excess_evt;
  logic ot_evt;
  logic force_ready;
  assign open_evt   = led_on && (open_filt_r == OPEN_FILT_LEN);  // R8
  assign warn_evt   = warn_s && ntc_active;                      // R9
  assign excess_evt = excess_s && ntc_active;                    // R10
  assign ot_evt     = ot_s && led_on;                            // R11
  // Warning alone never forces a mode change
  assign force_ready = open_evt || excess_evt || ot_evt ||
                       led_open_r || temp_excess_r || chip_ot_r ||
                       out_short_r;                              // R14

  // Mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_POR: begin
        if (por_cnt_r == 6'(POR_CYC - 1)) begin
          mode_nxt = MODE_SHUTDOWN;                              // R15
        end
      end
      MODE_SHUTDOWN: begin
        if (cmd_r[CMD_POWER_UP]) begin
          mode_nxt = MODE_PRECHARGE;                             // R18
        end
      end
      MODE_PRECHARGE: begin
        if (!cmd_r[CMD_POWER_UP]) begin
          mode_nxt = MODE_SHUTDOWN;                              // R16
        end else if (vok_s) begin
          mode_nxt = MODE_READY;                                 // R12
        end else if (pre_cnt_r == CNT_W'(PRECHARGE_CYCLES - 1)) begin
          mode_nxt = MODE_SHUTDOWN;                              // R12
        end
      end
      MODE_READY: begin
        if (!cmd_r[CMD_POWER_UP]) begin
          mode_nxt = MODE_SHUTDOWN;                              // R16
        end else if (!force_ready && flash_req) begin
          mode_nxt = MODE_FLASH;                                 // R23
        end else if (!force_ready && cmd_r[CMD_TORCH_ON]) begin
          mode_nxt = MODE_TORCH;
        end
      end
      MODE_TORCH: begin
        if (!cmd_r[CMD_POWER_UP]) begin
          mode_nxt = MODE_SHUTDOWN;                              // R16
        end else if (force_ready || !cmd_r[CMD_TORCH_ON]) begin
          mode_nxt = MODE_READY;                                 // R18
        end else if (flash_req) begin
          mode_nxt = MODE_FLASH;
        end
      end
      MODE_FLASH: begin
        if (!cmd_r[CMD_POWER_UP]) begin
          mode_nxt = MODE_SHUTDOWN;                              // R16
        end else if (force_ready || !flash_req || tmo_hit) begin
          // Strobe pulse length sets how long flash lasts
          mode_nxt = MODE_READY;                                 // R18 R20
        end
      end
      default: begin
        mode_nxt = MODE_SHUTDOWN;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r <= MODE_POR;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Reset period timer; address pin caught at its end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_cnt_r        <= 6'h00;
      slave_addr_sel_o <= 1'b0;
    end else if (in_por) begin
      por_cnt_r <= por_cnt_r + 6'h01;
      if (mode_nxt == MODE_SHUTDOWN) begin
        slave_addr_sel_o <= addr_s;                              // R15
      end
    end
  end

  // Precharge timer restarts on every entry
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pre_cnt_r <= '0;
    end else if (mode_r == MODE_PRECHARGE) begin
      pre_cnt_r <= pre_cnt_r + CNT_W'(1);                        // R12
    end else begin
      pre_cnt_r <= '0;
    end
  end

  // Command register; hardware clears beat stale bits, writes win
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_r <= REG_RESET;
    end else if (cmd_wr) begin
      cmd_r <= reg_wdata_i;
    end else begin
      if (tmo_hit) begin
        cmd_r[CMD_STROBE_EN] <= 1'b0;                            // R22
      end
      // Failed start: drop power bit so it does not retry blindly
      if (mode_r == MODE_PRECHARGE && mode_nxt == MODE_SHUTDOWN) begin
        cmd_r[CMD_POWER_UP] <= 1'b0;                             // R12
      end
    end
  end

  // Dimming and indicator registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dim_r <= REG_RESET;
      ind_r <= REG_RESET;
    end else if (wr_ok) begin
      if (reg_addr_i == OFS_DIMMING) begin
        dim_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_INDICATOR) begin
        ind_r <= reg_wdata_i;
      end
    end
  end

  // Flash timeout counter: runs only in flash, keeps its count
  // between strobe pulses, the field itself is never touched
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tmo_left_r <= 4'h0;
      tmo_sub_r  <= '0;
    end else if (cmd_wr) begin
      tmo_left_r <= reg_wdata_i[CMD_TMO_HI:CMD_TMO_LO];          // R21
      tmo_sub_r  <= '0;
    end else if (mode_r == MODE_FLASH && tmo_left_r != 4'h0) begin
      if (tmo_sub_r == CNT_W'(STEP_CYCLES - 1)) begin
        tmo_sub_r  <= '0;
        tmo_left_r <= tmo_left_r - 4'h1;                         // R24
      end else begin
        tmo_sub_r <= tmo_sub_r + CNT_W'(1);                      // R21
      end
    end
  end

  // Open-LED filter: comparator must hold before it counts
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      open_filt_r <= 3'h0;
    end else if (open_s && led_on) begin
      if (open_filt_r != OPEN_FILT_LEN) begin
        open_filt_r <= open_filt_r + 3'h1;                       // R8
      end
    end else begin
      open_filt_r <= 3'h0;
    end
  end

  // Latched faults; a set in the read cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      led_open_r    <= 1'b0;
      temp_warn_r   <= 1'b0;
      temp_excess_r <= 1'b0;
      chip_ot_r     <= 1'b0;
      tmo_pend_r    <= 1'b0;
    end else begin
      led_open_r    <= open_evt   || (led_open_r    && !stat_rd); // R8 R13
      temp_warn_r   <= warn_evt   || (temp_warn_r   && !stat_rd); // R9 R13
      temp_excess_r <= excess_evt || (temp_excess_r && !stat_rd); // R10
      chip_ot_r     <= ot_evt     || (chip_ot_r     && !stat_rd); // R11
      tmo_pend_r    <= tmo_hit    || (tmo_pend_r    && !stat_rd); // R22
    end
  end

  // Output-short flag: set on start-up, cleared by threshold or read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_short_r <= 1'b0;
    end else if (mode_r == MODE_SHUTDOWN && mode_nxt == MODE_PRECHARGE) begin
      out_short_r <= 1'b1;                                       // R12
    end else if (mode_r == MODE_PRECHARGE && vok_s) begin
      out_short_r <= 1'b0;                                       // R12
    end else if (stat_rd) begin
      out_short_r <= 1'b0;                                       // R13
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= REG_RESET;
    end else if (reg_rd_i && !in_por) begin
      if (reg_addr_i == OFS_COMMAND) begin
        reg_rdata_o <= cmd_r;
      end else if (reg_addr_i == OFS_DIMMING) begin
        reg_rdata_o <= dim_r;
      end else if (reg_addr_i == OFS_INDICATOR) begin
        reg_rdata_o <= ind_r;
      end else if (reg_addr_i == OFS_FAULT_STATUS) begin
        reg_rdata_o <= REG_RESET;
        reg_rdata_o[ST_FLASH_RUN]   <= (mode_r == MODE_FLASH);  // R7
        reg_rdata_o[ST_LED_OPEN]    <= led_open_r;
        reg_rdata_o[ST_TEMP_WARN]   <= temp_warn_r;
        reg_rdata_o[ST_TEMP_EXCESS] <= temp_excess_r;
        reg_rdata_o[ST_CHIP_OT]     <= chip_ot_r;
        reg_rdata_o[ST_OUT_SHORT]   <= out_short_r;
      end else begin
        reg_rdata_o <= REG_RESET;
      end
    end
  end

  // Indicator on-time timer
  indicator_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_ind_timer (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .load_i     (ind_wr),
    .cur_code_i (reg_wdata_i[IND_CUR_HI:IND_CUR_LO]),
    .on_time_i  (reg_wdata_i[IND_TIME_HI:IND_TIME_LO]),
    .lit_o      (ind_lit)
  );

  // Linear current decode: code * 40 / 3 matches the 0.1 mA scale
  assign ind_prod = ({6'h00, ind_r[IND_CUR_HI:IND_CUR_LO]} * IND_CUR_NUM)
                    / IND_CUR_DEN;                               // R5

  // Level step for the active LED mode
  logic [4:0] step_now;
  always_comb begin
    step_now = 5'h00;
    if (mode_r == MODE_TORCH) begin
      step_now = {1'b0, dim_r[DIM_TORCH_HI:DIM_TORCH_LO]} +
                 TORCH_STEP_BASE;                                // R6
    end else if (mode_r == MODE_FLASH) begin
      step_now = {1'b0, dim_r[DIM_FLASH_HI:DIM_FLASH_LO]} +
                 FLASH_STEP_BASE;                                // R6
    end
  end

  // All outputs registered; one cycle behind the mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      alert_n_pin_o       <= 1'b0;
      alert_n_pin_oe_o    <= 1'b0;
      analog_en_o         <= 1'b0;
      precharge_en_o      <= 1'b0;
      converter_en_o      <= 1'b0;
      ntc_monitor_en_o    <= 1'b0;
      led_step_o          <= 5'h00;
      sense_flash_only_o  <= 1'b0;
      indicator_on_o      <= 1'b0;
      indicator_current_o <= 8'h00;
      flash_active_o      <= 1'b0;
    end else begin
      // Pin only ever pulls low; floats during reset period
      alert_n_pin_o    <= 1'b0;
      alert_n_pin_oe_o <= !in_por &&
                          (led_open_r || temp_warn_r || temp_excess_r ||
                           chip_ot_r || out_short_r || tmo_pend_r); // R14 R25
      analog_en_o    <= (mode_r != MODE_POR) && (mode_r != MODE_SHUTDOWN);
      precharge_en_o <= (mode_r == MODE_PRECHARGE);              // R12
      // Converter only runs with the LED; ready keeps it off
      converter_en_o     <= led_on;                              // R17
      ntc_monitor_en_o   <= ntc_active;
      led_step_o         <= step_now;                            // R6
      sense_flash_only_o <= (step_now >= FLASH_PATH_STEP);       // R6
      // Indicator lights only in ready mode
      indicator_on_o      <= ind_lit && (mode_r == MODE_READY);  // R17
      indicator_current_o <= (ind_lit && mode_r == MODE_READY) ?
                             ind_prod[7:0] : 8'h00;              // R5
      flash_active_o      <= (mode_r == MODE_FLASH);             // R7
    end
  end

endmodule : flash_led_ctrl

// ---- flash_led_ctrl_checker.sv ----
`timescale 1ns/1ps

// Port-level watch on the flash LED controller
module flash_led_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       alert_n_pin_o,
  input wire logic       alert_n_pin_oe_o,
  input wire logic       analog_en_o,
  input wire logic       precharge_en_o,
  input wire logic       converter_en_o,
  input wire logic [4:0] led_step_o,
  input wire logic       sense_flash_only_o,
  input wire logic       indicator_on_o,
  input wire logic [7:0] indicator_current_o,
  input wire logic       flash_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sense_split_a: assert property (led_step_o != 5'h00 |->
    sense_flash_only_o == (led_step_o >= 5'h0D) && led_step_o <= 5'h18)
    else $error("sense path or step range wrong");
  flash_step_a: assert property (flash_active_o |->
    led_step_o >= 5'h09 && converter_en_o) else $error("flash step wrong");
  ind_ready_a: assert property (indicator_on_o |-> analog_en_o &&
    !converter_en_o && !precharge_en_o) else $error("indicator outside ready");
  ind_current_a: assert property ((indicator_current_o != 8'h00) ==
    indicator_on_o) else $error("indicator current mismatch");
  drain_only_a: assert property (alert_n_pin_o == 1'b0)
    else $error("alert pin driven high");
  shutdown_idle_a: assert property (!analog_en_o |-> !converter_en_o &&
    !flash_active_o) else $error("activity in shutdown");
  ready_first_a: assert property ($rose(converter_en_o) |->
    $past(analog_en_o)) else $error("converter started from shutdown");
  charge_dark_a: assert property (precharge_en_o |->
    led_step_o == 5'h00 && !converter_en_o) else $error("LED lit in charge");
  // Reset itself is the cause here, so it may not disable the check
  reset_quiet_a: assert property (disable iff (1'b0) srst_i |=>
    !alert_n_pin_oe_o && !analog_en_o) else $error("outputs live in reset");
  cover property ($rose(flash_active_o));
  cover property ($rose(indicator_on_o));
  cover property ($rose(alert_n_pin_oe_o));
endmodule : flash_led_ctrl_checker

bind flash_led_ctrl flash_led_ctrl_checker flash_led_ctrl_checker_i (
  .clk_i, .srst_i, .alert_n_pin_o, .alert_n_pin_oe_o, .analog_en_o,
  .precharge_en_o, .converter_en_o, .led_step_o, .sense_flash_only_o,
  .indicator_on_o, .indicator_current_o, .flash_active_o);

// ---- vout_model.sv ----
`timescale 1ns/1ps

// Output capacitor: crosses its threshold some cycles into charging
module vout_model (
  input  wire logic clk_i,
  input  wire logic analog_en_i,
  input  wire logic shorted_i,   // Shorted output never reaches the threshold
  output logic      vout_ok_o
);
  logic [3:0] charge_r;          // Cycles of charging so far
  // Discharged whenever the analog side is off
  always_ff @(posedge clk_i) begin
    if (!analog_en_i) charge_r <= 4'h0;
    else if (charge_r != 4'hF) charge_r <= charge_r + 4'h1;
  end
  assign vout_ok_o = (charge_r >= 4'h8) && !shorted_i;
endmodule : vout_model

// ---- flash_led_ctrl_tb_top.sv ----
`timescale 1ns/1ps

module flash_led_ctrl_tb_top;
  import flash_led_pkg::*;
  logic       clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic       strobe_pin_input_i = 0, led_open_cmp_i = 0, shorted = 1;
  logic       vout_ok_cmp_i, alert_n_pin_o, alert_n_pin_oe_o, analog_en_o;
  logic       slave_addr_sel_o, precharge_en_o, converter_en_o;
  logic       ntc_monitor_en_o, sense_flash_only_o, indicator_on_o;
  logic       flash_active_o, temp_warn_cmp_i = 0;
  logic [4:0] led_step_o;
  logic [7:0] indicator_current_o;
  int         fail_count = 0, total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  // Short counts keep the timeout and precharge tests brief
  flash_led_ctrl #(.STEP_CYCLES(20), .PRECHARGE_CYCLES(30)) flash_led_ctrl_i (
    .clk_i, .srst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .strobe_pin_input_i, .addr_sel_pin_i(1'b1),
    .led_open_cmp_i, .temp_warn_cmp_i, .temp_excess_cmp_i(1'b0),
    .chip_overtemp_i(1'b0), .vout_ok_cmp_i, .alert_n_pin_o,
    .alert_n_pin_oe_o, .slave_addr_sel_o, .analog_en_o, .precharge_en_o,
    .converter_en_o, .ntc_monitor_en_o, .led_step_o, .sense_flash_only_o,
    .indicator_on_o, .indicator_current_o, .flash_active_o);
  vout_model vout_model_i (.clk_i, .analog_en_i(analog_en_o),
    .shorted_i(shorted), .vout_ok_o(vout_ok_cmp_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 0;
  endtask : wr
  // Read data is settled by the following falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_rd_i = 1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 0;
    chk(reg_rdata_o, exp);
  endtask : rd
  // Shorted output aborts start-up, then a clean start
  task automatic t_startup;
    wr(OFS_COMMAND, 8'h80);
    cyc(40);
    chk(alert_n_pin_oe_o, 8'h01);
    rd(OFS_COMMAND, 8'h00);
    rd(OFS_FAULT_STATUS, 8'h01);
    cyc(2);
    chk(alert_n_pin_oe_o, 8'h00);
    shorted = 0;
    wr(OFS_COMMAND, 8'h80);
    cyc(20);
    rd(OFS_FAULT_STATUS, 8'h00);
    chk({analog_en_o, slave_addr_sel_o}, 8'h03);
    $display("test startup done");
  endtask : t_startup
  task automatic t_indicator;
    wr(OFS_INDICATOR, 8'hF2);
    cyc(5);
    chk(indicator_current_o, 8'hC8);
    cyc(60);
    chk(indicator_on_o, 8'h00);
    wr(OFS_INDICATOR, 8'h0F);
    cyc(5);
    chk(indicator_on_o, 8'h00);
    $display("test indicator done");
  endtask : t_indicator
  // Open LED during torch drops back to ready until status is read
  task automatic t_torch;
    wr(OFS_DIMMING, 8'h3A);
    wr(OFS_COMMAND, 8'hA0);
    cyc(5);
    chk({ntc_monitor_en_o, 2'b00, led_step_o}, 8'h84);
    {led_open_cmp_i, temp_warn_cmp_i} = 2'b11;
    cyc(15);
    {led_open_cmp_i, temp_warn_cmp_i} = 2'b00;
    chk({converter_en_o, alert_n_pin_oe_o}, 8'h01);
    rd(OFS_FAULT_STATUS, 8'h30);
    wr(OFS_COMMAND, 8'h80);
    cyc(3);
    chk(alert_n_pin_oe_o, 8'h00);
    $display("test torch done");
  endtask : t_torch
  // Two pulses: neither alone reaches the limit, together they do
  task automatic t_flash;
    wr(OFS_COMMAND, 8'hC1);
    strobe_pin_input_i = 1;
    cyc(8);
    chk({sense_flash_only_o, 2'b00, led_step_o}, 8'h93);
    rd(OFS_FAULT_STATUS, 8'h40);
    strobe_pin_input_i = 0;
    cyc(6);
    chk(flash_active_o, 8'h00);
    strobe_pin_input_i = 1;
    cyc(19);
    chk({flash_active_o, alert_n_pin_oe_o}, 8'h01);
    strobe_pin_input_i = 0;
    rd(OFS_COMMAND, 8'h81);
    rd(OFS_FAULT_STATUS, 8'h00);
    cyc(2);
    chk(alert_n_pin_oe_o, 8'h00);
    $display("test flash done");
  endtask : t_flash
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #(25 * 4000);
    fail_count++;
    print_verdict();
  end
  initial begin
    cyc(6);
    srst_i = 0;
    cyc(45);
    t_startup();
    t_indicator();
    t_torch();
    t_flash();
    print_verdict();
  end
endmodule : flash_led_ctrl_tb_top
